/* bench/flash_host_model.sv */
// Host side of the serial link: clock, select and lane pins.
// Assumes the device's lane outputs and enables fed back here.
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  logic [3:0] hd = 4'hc;
  logic [3:0] he = 4'hd;
  logic cpol = 1'b0;
  logic tg = 1'b0;
  always @(posedge clk) tg <= ~tg;
  // Undriven lanes with he clear toggle, so a stale level never passes for data; with he set they hold hd
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & ((he & hd) | (~he & {4{tg}})));
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  task automatic sel;
    @(negedge clk) cs_n = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic desel;
    @(negedge clk) cs_n = 1'b1;
    repeat (4) @(negedge clk);
    sck = cpol;
    repeat (8) @(negedge clk);
  endtask
  // Data set while clock low, read just before the next fall
  task automatic xfer(input int w, input int n, input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    repeat (n) begin
      @(negedge clk) sck = 1'b0;
      hd = w == 1 ? {hd[3:1], d[7]} : w == 2 ? {hd[3:2], d[7:6]} : d[7:4];
      d = d << w;
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      q = w == 1 ? {q[6:0], lane_in[1]} : w == 2 ? {q[5:0], lane_in[1:0]} : {q[3:0], lane_in};
    end
  endtask
endmodule // flash_host_model
`default_nettype wire

/* bench/flash_pin_front_monitor.sv */
// Checker on the pin front end ports.
// Assumes one clock domain, nrst asynchronous active low.
`timescale 1ns/1ns
`default_nettype none
module flash_pin_front_monitor (
  // Clock, reset and pins
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic data_lane_two_in,
  // Lane enables
  input wire logic data_lane_zero_oe,
  input wire logic data_lane_one_oe,
  input wire logic data_lane_two_oe,
  input wire logic data_lane_three_oe,
  // Stream pulses
  input wire logic rx_valid,
  input wire logic tx_take,
  // Status write
  input wire logic status_wr,
  input wire logic [5:0] status_wr_data,
  input wire logic status_wr_reject,
  input wire logic status_lock_bit,
  input wire logic four_lane_enable_bit,
  input wire logic [3:0] protect_level_bits,
  // Frame state
  input wire logic selected,
  input wire logic paused,
  input wire logic frame_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic oe_any;
  assign oe_any = data_lane_zero_oe | data_lane_one_oe | data_lane_two_oe | data_lane_three_oe;
  a_deselect_release: assert property (cs_n [*8] |-> !oe_any) else $error("lane driven idle");
  a_frame_begin: assert property (frame_start |=> $rose(selected) && !frame_start) else $error("no start");
  a_idle_no_rx: assert property (cs_n [*8] |-> !rx_valid) else $error("byte while idle");
  a_locked_reject: assert property ((!data_lane_two_in [*4] ##0 (status_wr && status_lock_bit
    && !four_lane_enable_bit)) |=> status_wr_reject && $stable(protect_level_bits)) else $error("lock");
  a_open_write: assert property (status_wr && !status_lock_bit |=> !status_wr_reject && {status_lock_bit,
    four_lane_enable_bit, protect_level_bits} == $past(status_wr_data)) else $error("write lost");
  a_quad_no_lock: assert property (status_wr && four_lane_enable_bit |=> !status_wr_reject) else $error("rej");
  a_quad_no_pause: assert property (four_lane_enable_bit && $past(four_lane_enable_bit) |-> !paused)
    else $error("pause in quad");
  a_pause_release: assert property (paused [*5] |-> !oe_any) else $error("lane driven paused");
  cover property (frame_start);
  cover property (status_wr_reject);
  cover property (tx_take);
  cover property (paused [*5]);
endmodule // flash_pin_front_monitor
bind flash_pin_front flash_pin_front_monitor i_mon (.clk, .nrst, .cs_n, .data_lane_two_in, .rx_valid,
  .tx_take, .data_lane_zero_oe, .data_lane_one_oe, .data_lane_two_oe, .data_lane_three_oe, .status_wr,
  .status_wr_reject, .status_lock_bit, .four_lane_enable_bit, .selected, .paused, .frame_start,
  .status_wr_data, .protect_level_bits);
`default_nettype wire

/* bench/serial_flash_pin_front_end_test.sv */
// Self-checking bench for the flash pin front end.
// Assumes the host model and bound checker compiled before it.
`timescale 1ns/1ns
`default_nettype none
module serial_flash_pin_front_end_test;
  logic clk, nrst, sck, cs_n, drive_out, status_wr, rx_valid, tx_take;
  logic rej, lock, four, selected, standby, paused, frame_start;
  logic [1:0] lane_mode;
  logic [7:0] tx_byte, rx_byte, got, r, q;
  logic [5:0] status_wr_data;
  logic [3:0] lane_in, prot;
  wire [3:0] lane_out, lane_oe;
  int fail_count, checks, takes;
  flash_pin_front i_dut (.clk, .nrst, .sck, .cs_n,
    .data_lane_zero_in(lane_in[0]), .data_lane_one_in(lane_in[1]),
    .data_lane_two_in(lane_in[2]), .data_lane_three_in(lane_in[3]),
    .data_lane_zero_out(lane_out[0]), .data_lane_one_out(lane_out[1]),
    .data_lane_two_out(lane_out[2]), .data_lane_three_out(lane_out[3]),
    .data_lane_zero_oe(lane_oe[0]), .data_lane_one_oe(lane_oe[1]),
    .data_lane_two_oe(lane_oe[2]), .data_lane_three_oe(lane_oe[3]),
    .lane_mode, .drive_out, .rx_byte, .rx_valid, .tx_byte, .tx_take, .status_wr, .status_wr_data,
    .status_wr_reject(rej), .status_lock_bit(lock), .four_lane_enable_bit(four),
    .protect_level_bits(prot), .selected, .standby, .paused, .frame_start);
  flash_host_model host (.clk, .sck, .cs_n, .lane_in, .lane_out, .lane_oe);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rx_valid === 1'b1) got <= rx_byte;
  always @(posedge clk) if (tx_take === 1'b1) takes <= takes + 1;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Entry bits: lock, four-lane, write-lock pin level, refused
  task automatic st(input logic [3:0] e);
    logic [5:0] old;
    old = {lock, four, prot};
    host.hd[2] = e[1];
    repeat (4) @(negedge clk);
    status_wr_data = {e[3:2], 4'($urandom)};
    status_wr = 1'b1;
    @(negedge clk) status_wr = 1'b0;
    chk({7'h0, rej}, {7'h0, e[0]});
    chk({2'h0, lock, four, prot}, {2'h0, e[0] ? old : status_wr_data});
  endtask
  initial begin
    #900000;
    fail_count++;
    complete_run;
  end
  initial begin
    int w;
    nrst = 1'b0;
    drive_out = 1'b0;
    status_wr = 1'b0;
    lane_mode = 2'h0;
    tx_byte = 8'h00;
    status_wr_data = 6'h00;
    got = 8'h00;
    fail_count = 0;
    checks = 0;
    void'($urandom(87));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({lane_oe, standby, selected, lock, four}, 8'h08);
    host.xfer(1, 8, 8'ha5, q);
    repeat (8) @(negedge clk);
    chk({got[6:0], selected}, 8'h00);
    host.desel;
    done("idle");
    st(4'h8);
    st(4'h1);
    st(4'h2);
    st(4'he);
    st(4'h0);
    done("status");
    r = 8'($urandom);
    host.sel;
    host.xfer(1, 4, r, q);
    host.hd[3] = 1'b0;
    repeat (8) @(negedge clk);
    chk({lane_oe, 3'h0, paused}, 8'h01);
    host.hd[3] = 1'b1;
    repeat (8) @(negedge clk);
    host.xfer(1, 4, r << 4, q);
    repeat (4) @(negedge clk);
    chk(got, r);
    host.desel;
    done("pause");
    st(4'h6);
    for (int m = 0; m < 3; m++) begin
      w = 1 << m;
      host.cpol = m[0];
      host.sck = m[0];
      lane_mode = m[1:0];
      r = 8'($urandom);
      tx_byte = 8'($urandom);
      host.he = m == 0 ? 4'hd : 4'hf;
      host.sel;
      host.xfer(w, 8 / w, r, q);
      repeat (4) @(negedge clk);
      chk(got, r);
      takes = 0;
      drive_out = 1'b1;
      host.he = m == 0 ? 4'hd : m == 1 ? 4'hc : 4'h0;
      host.xfer(w, 8 / w, 8'h00, q);
      chk(q, tx_byte);
      chk(takes[7:0], 8'h01);
      drive_out = 1'b0;
      host.desel;
      chk({lane_oe, standby, 3'h0}, 8'h08);
      done("lanes");
    end
    complete_run;
  end
endmodule // serial_flash_pin_front_end_test
`default_nettype wire

/* core/flash_pin_front.v */
// Pin front end of a serial NOR flash: select, lanes, pause,
// status write lock. The serial clock is sampled by clk, so it
// must run well below clk/4. The command core sits behind the
// user ports and decides lane mode and when read data flows.
//
// How it works
// - Chip select high: all pins released
// - Deselected: standby, internal shifting stopped
// - Chip select low: active, accepts traffic
// - After reset, need a select falling edge
// - Ignore serial activity while chip select high
// - Single lane: sample lane zero on rise
// - Single lane: drive lane one on fall
// - Dual/quad: lanes bidirectional, rise in, fall out
// - Quad uses write-lock and pause pins as lanes
// - Lock set, pin low: reject protected writes
// - Lock clear: status writes always allowed
// - Four-lane bit kills write-lock pin function
// - Four-lane bit kills pause pin function
// - Pause low freezes sequence, keeps partial bits
// - Paused and selected: output line released
// - Pause released: resume where it stopped
// - Clock modes 0 and 3 both work
`timescale 1ns/1ns
`default_nettype none
`include "flash_front_consts.vh"

module flash_pin_front #(
  parameter [`ST_WIDTH-1:0] STATUS_INIT = `ST_RESET
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Serial pins from the host
  input wire sck,
  input wire cs_n,
  // Data lane pins, in, out and enable
  input wire data_lane_zero_in,
  input wire data_lane_one_in,
  input wire data_lane_two_in,
  input wire data_lane_three_in,
  output reg data_lane_zero_out,
  output reg data_lane_one_out,
  output reg data_lane_two_out,
  output reg data_lane_three_out,
  output reg data_lane_zero_oe,
  output reg data_lane_one_oe,
  output reg data_lane_two_oe,
  output reg data_lane_three_oe,
  // Command core: mode and direction
  input wire [1:0] lane_mode,
  input wire drive_out,
  // Command core: received bytes
  output reg [7:0] rx_byte,
  output reg rx_valid,
  // Command core: bytes to send
  input wire [7:0] tx_byte,
  output reg tx_take,
  // Command core: status write request
  input wire status_wr,
  input wire [`ST_WIDTH-1:0] status_wr_data,
  output reg status_wr_reject,
  // Status bits held here
  output reg status_lock_bit,
  output reg four_lane_enable_bit,
  output reg [3:0] protect_level_bits,
  // Frame state
  output reg selected,
  output reg standby,
  output reg paused,
  output reg frame_start
);

  ////////////////////////////////////////////////////////////
  // Pin synchronisers

  wire [`SYNC_WIDTH-1:0] pins_raw;
  wire [`SYNC_WIDTH-1:0] pins_sync;

  assign pins_raw = {sck, cs_n,
                     data_lane_three_in, data_lane_two_in,
                     data_lane_one_in, data_lane_zero_in};

  pin_sync #(
    .WIDTH(`SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  wire sck_s;
  wire cs_n_s;
  wire [3:0] lanes_s;

  assign sck_s = pins_sync[5];
  assign cs_n_s = pins_sync[4];
  assign lanes_s = pins_sync[3:0];

  ////////////////////////////////////////////////////////////
  // Edge detection on synchronised clock and select

  reg sck_d_reg;
  reg cs_n_d_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b0; // Same as synchroniser reset: no false fall
    end else begin
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  wire sck_rise;
  wire sck_fall;
  wire cs_fall;

  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;

  ////////////////////////////////////////////////////////////
  // Select and standby

  // Reset leaves select low until the host toggles it
  reg cs_high_seen_reg;
  reg armed_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_high_seen_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      if (cs_n_s)
        cs_high_seen_reg <= 1'b1;
      if (cs_n_s)
        armed_reg <= 1'b0;
      else if (cs_fall && cs_high_seen_reg)
        armed_reg <= 1'b1;
    end
  end

  wire active;
  assign active = armed_reg & ~cs_n_s;

  ////////////////////////////////////////////////////////////
  // Pin functions: write lock and pause

  // Four-lane bit turns both pins into plain data lanes
  wire wp_n;
  wire hold_n;

  assign wp_n = four_lane_enable_bit | lanes_s[2];
  assign hold_n = four_lane_enable_bit | lanes_s[3];

  wire hold_now;
  assign hold_now = active & ~hold_n;

  // Edges seen while paused are dropped, state is kept
  wire run;
  assign run = active & ~hold_now;

  wire rise_ok;
  wire fall_ok;

  assign rise_ok = run & sck_rise;
  assign fall_ok = run & sck_fall;

  ////////////////////////////////////////////////////////////
  // Effective lane mode

  // Quad only when lanes two and three are freed for data
  reg [1:0] mode_eff;
  reg [2:0] step;

  always @* begin
    mode_eff = lane_mode;
    if (lane_mode == `LANE_QUAD && !four_lane_enable_bit)
      mode_eff = `LANE_DUAL;
    else if (lane_mode != `LANE_QUAD && lane_mode != `LANE_DUAL)
      mode_eff = `LANE_SINGLE;
    case (mode_eff)
      `LANE_DUAL: step = `BITS_DUAL;
      `LANE_QUAD: step = `BITS_QUAD;
      default: step = `BITS_SINGLE;
    endcase
  end

  ////////////////////////////////////////////////////////////
  // Receive path

  reg [7:0] rx_sh_reg;
  reg [7:0] rx_sh_next;
  reg [3:0] rx_cnt_reg;
  reg [3:0] rx_cnt_next;

  // Multi-lane pins are shared, so no sampling while driving
  wire rx_en;
  assign rx_en = rise_ok & (mode_eff == `LANE_SINGLE | ~drive_out);

  always @* begin
    rx_sh_next = rx_sh_reg;
    rx_cnt_next = rx_cnt_reg;
    case (mode_eff)
      `LANE_DUAL: rx_sh_next = {rx_sh_reg[5:0], lanes_s[1:0]};
      `LANE_QUAD: rx_sh_next = {rx_sh_reg[3:0], lanes_s};
      default: rx_sh_next = {rx_sh_reg[6:0], lanes_s[0]};
    endcase
    rx_cnt_next = rx_cnt_reg + {1'b0, step};
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sh_reg <= 8'h00;
      rx_cnt_reg <= 4'h0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (cs_fall) begin
        rx_cnt_reg <= 4'h0;
      end else if (rx_en) begin
        rx_sh_reg <= rx_sh_next;
        if (rx_cnt_next >= `BYTE_BITS) begin
          rx_cnt_reg <= 4'h0;
          rx_byte <= rx_sh_next;
          rx_valid <= 1'b1;
        end else begin
          rx_cnt_reg <= rx_cnt_next;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Transmit path

  // Mode 3 idles high: the fall right after select carries
  // nothing, so output waits for a rise in this frame
  reg rise_seen_reg;
  reg [7:0] tx_sh_reg;
  reg [3:0] tx_left_reg;
  reg [7:0] tx_cur;
  reg [3:0] tx_left;

  always @* begin
    tx_cur = tx_sh_reg;
    tx_left = tx_left_reg;
    if (tx_left_reg == 4'h0) begin
      tx_cur = tx_byte;
      tx_left = `BYTE_BITS;
    end
  end

  wire tx_en;
  assign tx_en = fall_ok & drive_out & rise_seen_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rise_seen_reg <= 1'b0;
      tx_sh_reg <= 8'h00;
      tx_left_reg <= 4'h0;
      tx_take <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (cs_fall) begin
        rise_seen_reg <= 1'b0;
        tx_left_reg <= 4'h0;
      end else begin
        if (rise_ok)
          rise_seen_reg <= 1'b1;
        if (!drive_out) begin
          tx_left_reg <= 4'h0;
        end else if (tx_en) begin
          tx_take <= (tx_left_reg == 4'h0);
          tx_sh_reg <= tx_cur << step;
          tx_left_reg <= tx_left - {1'b0, step};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Lane drivers

  reg [3:0] lane_val_reg;
  reg [3:0] lane_en_reg;
  reg [3:0] lane_val_next;
  reg [3:0] lane_en_next;

  always @* begin
    lane_val_next = lane_val_reg;
    lane_en_next = lane_en_reg;
    if (tx_en) begin
      case (mode_eff)
        `LANE_DUAL: lane_val_next = {2'h0, tx_cur[7:6]};
        `LANE_QUAD: lane_val_next = tx_cur[7:4];
        default: lane_val_next = {2'h0, tx_cur[7], 1'b0};
      endcase
      case (mode_eff)
        `LANE_DUAL: lane_en_next = 4'h3;
        `LANE_QUAD: lane_en_next = 4'hf;
        default: lane_en_next = 4'h2;
      endcase
    end
    if (!drive_out)
      lane_en_next = 4'h0;
    if (!active || hold_now)
      lane_en_next = 4'h0;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_val_reg <= 4'h0;
      lane_en_reg <= 4'h0;
    end else begin
      lane_val_reg <= lane_val_next;
      lane_en_reg <= lane_en_next;
    end
  end

  always @* begin
    data_lane_zero_out = lane_val_reg[0];
    data_lane_one_out = lane_val_reg[1];
    data_lane_two_out = lane_val_reg[2];
    data_lane_three_out = lane_val_reg[3];
    data_lane_zero_oe = lane_en_reg[0];
    data_lane_one_oe = lane_en_reg[1];
    data_lane_two_oe = lane_en_reg[2];
    data_lane_three_oe = lane_en_reg[3];
  end

  ////////////////////////////////////////////////////////////
  // Protected status bits

  wire locked;
  assign locked = status_lock_bit & ~wp_n;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_lock_bit <= STATUS_INIT[`ST_LOCK];
      four_lane_enable_bit <= STATUS_INIT[`ST_FOUR];
      protect_level_bits <= STATUS_INIT[`ST_PROT_HI:`ST_PROT_LO];
      status_wr_reject <= 1'b0;
    end else begin
      status_wr_reject <= 1'b0;
      if (status_wr) begin
        if (locked) begin
          status_wr_reject <= 1'b1;
        end else begin
          status_lock_bit <= status_wr_data[`ST_LOCK];
          four_lane_enable_bit <= status_wr_data[`ST_FOUR];
          protect_level_bits <= status_wr_data[`ST_PROT_HI:`ST_PROT_LO];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Frame state outputs

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      selected <= 1'b0;
      standby <= 1'b1;
      paused <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      selected <= active;
      standby <= ~active;
      paused <= hold_now;
      frame_start <= cs_fall & cs_high_seen_reg;
    end
  end

endmodule // flash_pin_front

`default_nettype wire

/* core/pin_sync.v */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes single clock clk; the inputs are asynchronous to it.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter WIDTH = 6
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Pins in, synchronised copy out
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] meta_reg;

  // First stage is read only by the second
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= {WIDTH{1'b0}};
      pin_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= pin_in;
      pin_out <= meta_reg;
    end
  end

endmodule // pin_sync

`default_nettype wire

/* pkg/flash_front_consts.vh */
// Constants for the serial flash pin front end.
// Included by the pin front end core; holds definitions only.
`ifndef FLASH_FRONT_CONSTS_VH
`define FLASH_FRONT_CONSTS_VH

// Lane modes requested by the command core
`define LANE_SINGLE 2'h0
`define LANE_DUAL 2'h1
`define LANE_QUAD 2'h2

// Bits moved per serial clock edge, per mode
`define BITS_SINGLE 3'h1
`define BITS_DUAL 3'h2
`define BITS_QUAD 3'h4

// Bits in one byte on the link
`define BYTE_BITS 4'h8

// Field positions of the protected status bits
`define ST_LOCK 5
`define ST_FOUR 4
`define ST_PROT_HI 3
`define ST_PROT_LO 0
`define ST_WIDTH 6

// Status value at power-up
`define ST_RESET 6'h00

// Pin synchroniser width: sck, cs, four lanes
`define SYNC_WIDTH 6

`endif
